//--- ppo_pkg.sv
// Package for the programmable pulse output block
package ppo_pkg;
	typedef enum logic [2:0] {
		PPO_IDLE,
		PPO_CYCLIC,
		PPO_SINGLE,
		PPO_TIMER,
		PPO_MINUTE_MARK
	} ppo_mode_t;

	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} ppo_hms_t;

	typedef struct packed {
		ppo_mode_t   mode;
		logic        active_high;
		logic        holdover_off;
		logic [15:0] pulse_ms;
		ppo_hms_t    cycle;
		ppo_hms_t    shot_time;
		ppo_hms_t    on_time;
		ppo_hms_t    off_time;
		logic [7:0]  mark_suspend_delay;
	} ppo_cfg_t;

	localparam int   PPO_CLK_MHZ      = 200;
	localparam int   PPO_MS_NS        = 1000000;
	localparam int   PPO_CLK_NS       = 1000 / PPO_CLK_MHZ;
	localparam int   PPO_CYC_PER_MS   = PPO_MS_NS / PPO_CLK_NS;
	localparam int   PPO_SEC_PER_DAY  = 86400;
	localparam logic [16:0] PPO_DAY_LAST = 17'h1517f;
	localparam logic [17:0] PPO_TZ_RESET = 18'h00000;
	localparam logic [7:0]  PPO_SEC_PER_MIN = 8'h3c;
	localparam logic [17:0] PPO_SEC_RESET = 18'h00000;
	localparam logic [16:0] PPO_SEC_PER_HR = 17'he10;
	localparam logic [16:0] PPO_SEC_PER_MN = 17'h3c;
	localparam logic signed [18:0] PPO_DAY_LEN = 19'sh15180;
endpackage

//--- ppo_core.sv
// Programmable pulse output: cyclic, single shot, timer and minute marks
// Behaviour
// - Cyclic mode repeats a pulse every configured hh:mm:ss interval.
// - Single-shot mode pulses once when local time reaches the set hh:mm:ss.
// - Minute-mark mode stops marks after the configured unsynchronised minutes.
// - Timer mode asserts the output from the on time until the off time.
// - The active level is selectable and, out of reset, the inactive level is its opposite; reset holds the output low.
// - With holdover shutdown set and the sync-only policy, losing sync deactivates the output on the third clock, after the two-flop synchroniser.
// - Holdover shutdown only acts when the enable policy is sync-only.
// - The policy drives outputs always, or only while synchronised.
// - Scheduling times of day include the time-zone offset.
`timescale 1ns/1ps
module ppo_core
	import ppo_pkg::*;
#(
	parameter int MS_CYCLES = PPO_CYC_PER_MS
) (
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire ppo_cfg_t    i_cfg,
	input  wire logic        i_sync_only,
	input  wire logic signed [17:0] i_tz_offset_s,
	input  wire logic        i_sec_tick,
	input  wire logic [16:0] i_tod_s,
	input  wire logic        i_synced,
	output logic             o_pulse,
	output logic             o_suspended
);
	logic        sync_m_ff;
	logic        sync_ff;
	logic [31:0] ms_div_ff;
	logic [15:0] ms_left_ff;
	logic [17:0] cyc_cnt_ff;
	logic [15:0] unsync_s_ff;
	logic        timer_on_ff;
	logic        out_ff;
	logic        susp_ff;

	function automatic logic [16:0] hms_sec(input ppo_hms_t t);
		hms_sec = 17'(t.hh) * PPO_SEC_PER_HR + 17'(t.mm) * PPO_SEC_PER_MN + 17'(t.ss);
	endfunction

	wire logic signed [18:0] loc_raw  = 19'(signed'({2'b00, i_tod_s})) + 19'(i_tz_offset_s);
	// One wrap only: offsets beyond a day are not expected
	wire logic signed [18:0] loc_wrp1 = loc_raw < 0 ? loc_raw + PPO_DAY_LEN : loc_raw;
	wire logic [16:0] loc_s = loc_wrp1 >= PPO_DAY_LEN ? 17'(loc_wrp1 - PPO_DAY_LEN)
		: 17'(loc_wrp1);

	wire logic enabled = !i_sync_only || sync_ff;
	wire logic hold_off = i_cfg.holdover_off && i_sync_only && !sync_ff;
	wire logic mark_susp = i_cfg.mode == PPO_MINUTE_MARK && !sync_ff
		&& unsync_s_ff >= 16'(i_cfg.mark_suspend_delay) * 16'(PPO_SEC_PER_MIN);
	wire logic inhibit = !enabled || hold_off || mark_susp;

	wire logic [16:0] cyc_len = hms_sec(i_cfg.cycle);
	wire logic cyc_hit  = i_sec_tick && cyc_len != 17'h0 && cyc_cnt_ff + 18'h1 >= 18'(cyc_len);
	wire logic ms_tick  = ms_div_ff == 32'(MS_CYCLES - 1);

	wire logic trig = i_sec_tick && !inhibit && (
		(i_cfg.mode == PPO_CYCLIC && cyc_hit) ||
		(i_cfg.mode == PPO_SINGLE && loc_s == hms_sec(i_cfg.shot_time)) ||
		(i_cfg.mode == PPO_MINUTE_MARK && loc_s % PPO_SEC_PER_MN == 17'h0));

	wire logic nxt_timer_on = !i_sec_tick ? timer_on_ff
		: loc_s == hms_sec(i_cfg.on_time) ? 1'b1
		: loc_s == hms_sec(i_cfg.off_time) ? 1'b0 : timer_on_ff;

	wire logic [15:0] nxt_ms_left = inhibit ? 16'h0
		: trig ? i_cfg.pulse_ms
		: (ms_tick && ms_left_ff != 16'h0) ? ms_left_ff - 16'h1 : ms_left_ff;

	wire logic active = !inhibit && (i_cfg.mode == PPO_TIMER ? timer_on_ff
		: ms_left_ff != 16'h0);
	wire logic nxt_out = i_cfg.active_high ? active : !active;

	// Divider restarts on a trigger so the first millisecond is whole
	wire logic [31:0] nxt_ms_div   = (ms_tick || trig) ? 32'h0 : ms_div_ff + 32'h1;
	wire logic [17:0] nxt_cyc_cnt  = !i_sec_tick ? cyc_cnt_ff
		: cyc_hit ? 18'h0 : cyc_cnt_ff + 18'h1;
	// Saturates so a long holdover cannot wrap back under the delay
	wire logic [15:0] nxt_unsync_s = sync_ff ? 16'h0
		: (i_sec_tick && unsync_s_ff != 16'hffff) ? unsync_s_ff + 16'h1 : unsync_s_ff;

	// Sync pin comes from another domain
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync_m_ff <= 1'b0;
			sync_ff   <= 1'b0;
		end else begin
			sync_m_ff <= i_synced;
			sync_ff   <= sync_m_ff;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			ms_div_ff  <= 32'h0;
			ms_left_ff <= 16'h0;
		end else begin
			ms_div_ff  <= nxt_ms_div;
			ms_left_ff <= nxt_ms_left;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cyc_cnt_ff <= PPO_SEC_RESET;
		end else begin
			cyc_cnt_ff <= nxt_cyc_cnt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			unsync_s_ff <= 16'h0;
		end else begin
			unsync_s_ff <= nxt_unsync_s;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			timer_on_ff <= 1'b0;
		end else begin
			timer_on_ff <= nxt_timer_on;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			out_ff  <= 1'b0;
			susp_ff <= 1'b0;
		end else begin
			out_ff  <= nxt_out;
			susp_ff <= inhibit;
		end
	end

	assign o_pulse     = out_ff;
	assign o_suspended = susp_ff;

	a_inhibit_level: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		inhibit |=> o_pulse == !$past(i_cfg.active_high))
		else $error("output not inactive while inhibited");
	a_holdover_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_cfg.holdover_off && i_sync_only && !sync_ff) |=> o_suspended)
		else $error("holdover shutdown missed");
	a_policy_always: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(!i_sync_only && i_cfg.mode != PPO_MINUTE_MARK) |=> !o_suspended)
		else $error("output suspended under always-on policy");
	a_sync_only: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_sync_only && !sync_ff) |=> o_suspended)
		else $error("sync-only policy not applied");
	a_pulse_start: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(trig && i_cfg.pulse_ms != 16'h0) |=> ms_left_ff == $past(i_cfg.pulse_ms))
		else $error("pulse length not loaded");
	a_polarity_act: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(active && i_cfg.active_high) |=> o_pulse)
		else $error("active level wrong");
	a_mark_susp: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		mark_susp |=> o_suspended)
		else $error("minute marks not suspended");
	a_timer_on: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_sec_tick && loc_s == hms_sec(i_cfg.on_time)) |=> timer_on_ff)
		else $error("timer window did not open");

	a_timer_off: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_sec_tick && loc_s == hms_sec(i_cfg.off_time)
		&& loc_s != hms_sec(i_cfg.on_time)) |=> !timer_on_ff)
		else $error("timer window did not close");

	a_polarity_idle: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(!active && i_cfg.active_high) |=> !o_pulse)
		else $error("inactive level wrong");

	a_polarity_low: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(active && !i_cfg.active_high) |=> !o_pulse)
		else $error("active low level wrong");

	a_shot_fire: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_sec_tick && !inhibit && i_cfg.mode == PPO_SINGLE && i_cfg.pulse_ms != 16'h0
		&& loc_s == hms_sec(i_cfg.shot_time)) |=> ms_left_ff != 16'h0)
		else $error("single shot missed");

	a_cycle_fire: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_sec_tick && !inhibit && i_cfg.mode == PPO_CYCLIC && cyc_hit
		&& i_cfg.pulse_ms != 16'h0) |=> ms_left_ff != 16'h0)
		else $error("cyclic pulse missed");

	a_cycle_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(i_sec_tick && cyc_hit) |=> cyc_cnt_ff == 18'h0)
		else $error("cycle counter not restarted");

	a_pulse_drop: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		inhibit |=> ms_left_ff == 16'h0)
		else $error("pulse kept while inhibited");

	a_pulse_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(!inhibit && !trig && !ms_tick) |=> $stable(ms_left_ff))
		else $error("pulse length moved between ticks");

	a_unsync_count: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		(!sync_ff && i_sec_tick && unsync_s_ff != 16'hffff)
		|=> unsync_s_ff == $past(unsync_s_ff) + 16'h1)
		else $error("unsynchronised seconds not counted");

	a_unsync_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		sync_ff |=> unsync_s_ff == 16'h0)
		else $error("unsynchronised count not cleared");
endmodule

//--- ppo_sink.sv
// Pulse consumer model: measures the active width of the line
`timescale 1ns/1ps
module ppo_sink (
	input  wire logic        i_mclk,
	input  wire logic        i_line,
	input  wire logic        i_act,
	output logic [15:0]      o_width
);
	logic [15:0] cnt = 16'h0;
	initial o_width = 16'h0;
	always @(posedge i_mclk) begin
		if (i_line === i_act) begin
			cnt <= cnt + 16'h1;
		end else if (cnt != 16'h0) begin
			o_width <= cnt;
			cnt <= 16'h0;
		end
	end
endmodule

//--- tb_top.sv
// Self-checking bench for the programmable pulse output
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
	$display("Error %s exp %0h got %0h", n, e, a); end end
module tb_top;
	import ppo_pkg::*;
	typedef struct packed {ppo_mode_t m; logic ah; logic [16:0] tod; logic act;} ppo_row_t;
	logic               i_mclk = 1'h0;
	logic               i_resetn = 1'h0;
	logic               i_sec_tick = 1'h0;
	logic               i_synced = 1'h1;
	logic               i_sync_only = 1'h0;
	logic [16:0]        i_tod_s = 17'h0;
	logic signed [17:0] i_tz_offset_s = 18'sh5;
	ppo_cfg_t           i_cfg = '0;
	logic               o_pulse;
	logic               o_suspended;
	logic [15:0]        w;
	int                 num_errors = 0;
	int                 compares = 0;
	int                 hits = 0;
	ppo_row_t rows [6] = '{'{PPO_SINGLE, 1'h1, 17'h5, 1'h1}, '{PPO_SINGLE, 1'h0, 17'h6, 1'h0},
		'{PPO_SINGLE, 1'h0, 17'h5, 1'h1}, '{PPO_TIMER, 1'h1, 17'hf, 1'h1},
		'{PPO_TIMER, 1'h1, 17'h11, 1'h0}, '{PPO_IDLE, 1'h1, 17'h5, 1'h0}};
	always #2.5 i_mclk = ~i_mclk;
	// Short millisecond keeps the run brief
	ppo_core #(.MS_CYCLES(10)) dut (.i_mclk, .i_resetn, .i_cfg, .i_sync_only, .i_tz_offset_s,
		.i_sec_tick, .i_tod_s, .i_synced, .o_pulse, .o_suspended);
	ppo_sink snk (.i_mclk(i_mclk), .i_line(o_pulse), .i_act(i_cfg.active_high), .o_width(w));
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	// Leaves off two edges after the tick, where the output has landed
	task automatic tick(input logic [16:0] t);
		@(negedge i_mclk);
		i_tod_s = t;
		i_sec_tick = 1'h1;
		@(negedge i_mclk);
		i_sec_tick = 1'h0;
		cyc(2);
	endtask
	task automatic stop_test;
		$display("Counts: %0d compares, %0d errors", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		stop_test;
	end
	initial begin
		i_cfg.pulse_ms = 16'h2;
		i_cfg.shot_time = 17'ha;
		i_cfg.on_time = 17'h14;
		i_cfg.off_time = 17'h16;
		cyc(8);
		`CHK("reset pulse", 1'h0, o_pulse)
		`CHK("reset suspended", 1'h0, o_suspended)
		$display("reset test done");
		i_resetn = 1'h1;
		foreach (rows[i]) begin
			i_cfg.mode = rows[i].m;
			i_cfg.active_high = rows[i].ah;
			cyc(30);
			tick(rows[i].tod);
			`CHK("row pulse", rows[i].act ? rows[i].ah : ~rows[i].ah, o_pulse)
			$display("row %0d done", i);
		end
		i_cfg.mode = PPO_SINGLE;
		tick(17'h5);
		cyc(30);
		`CHK("pulse width", 1'h1, w == 16'h14 || w == 16'h15)
		$display("width test done");
		i_cfg.holdover_off = 1'h1;
		tick(17'h5);
		i_synced = 1'h0;
		cyc(4);
		`CHK("always policy", 1'h1, o_pulse)
		i_sync_only = 1'h1;
		cyc(4);
		`CHK("holdover cut", 1'h0, o_pulse)
		`CHK("suspended", 1'h1, o_suspended)
		tick(17'h5);
		`CHK("dropped shot", 1'h0, o_pulse)
		i_synced = 1'h1;
		i_sync_only = 1'h0;
		cyc(4);
		`CHK("resumed", 1'h0, o_suspended)
		$display("holdover test done");
		i_cfg.mode = PPO_MINUTE_MARK;
		i_cfg.mark_suspend_delay = 8'h1;
		i_synced = 1'h0;
		for (int s = 0; s < 62; s++) tick(17'(s));
		`CHK("marks suspended", 1'h1, o_suspended)
		$display("mark test done");
		i_synced = 1'h1;
		i_cfg.mode = PPO_CYCLIC;
		i_cfg.cycle = 17'h3;
		for (int k = 0; k < 6; k++) begin
			cyc(30);
			tick(17'h0);
			hits += (o_pulse === 1'h1);
		end
		`CHK("cycle hits", 32'h2, hits)
		$display("cycle test done");
		stop_test;
	end
endmodule
